// ### current_defines.svh
`ifndef CURRENT_DEFINES_SVH
`define CURRENT_DEFINES_SVH

// ****************************************************************
// Clock and settling time
// ****************************************************************
`define CLK_FREQ_KHZ    50000
`define SETTLE_TIME_MS  1000
`define SETTLE_CYCLES   (`SETTLE_TIME_MS * `CLK_FREQ_KHZ)
`define SETTLE_CNT_W    26

// ****************************************************************
// Sample and magnitude widths
// ****************************************************************
`define SAMPLE_W        16
`define MAG_W           24
`define AVG_SHIFT       8
`define COMP_SHIFT      4

// ****************************************************************
// Thresholds
// ****************************************************************
// Mismatch: difference times 8 above active magnitude (12.5 %)
`define MISMATCH_SHIFT  3
// Swap: other * 50 above active * 57 (114 %)
`define SWAP_NUM        30'h0000039
`define SWAP_DEN        30'h0000032
// Light load: 0.3 % of full scale, on the averaged scale
`define LIGHT_LEVEL     24'h006200

`endif

// ### current_pkg.sv
package current_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic               valid;
    logic signed [15:0] data;
  } sample_s;

  typedef enum logic {
    SEL_PHASE,
    SEL_NEUTRAL
  } sel_e;

endpackage : current_pkg

// ### mag_avg.sv
`timescale 1ns/1ps
`default_nettype none
`include "current_defines.svh"

module mag_avg (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  clkEn,
  // Sample in, averaged magnitude out
  input  wire current_pkg::sample_s  sampleIn,
  output logic [`MAG_W-1:0]          magnitude
);
  import current_pkg::*;

  logic [`MAG_W-1:0] accQ;
  logic [`MAG_W-1:0] accD;
  logic [15:0]       absX;

  // Leaky integrator of |x|; settles near 256 times the mean magnitude
  assign absX = sampleIn.data[15] ? (~sampleIn.data + 16'h0001)
                                  : sampleIn.data;
  assign accD = accQ + {8'h00, absX} - (accQ >> `AVG_SHIFT);
  assign magnitude = accQ;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      accQ <= 24'h000000;
    end else if (clkEn && sampleIn.valid) begin
      accQ <= accD;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_mag_hold: assert property ((!clkEn || !sampleIn.valid) |=> $stable(accQ))
    else $error("magnitude moved without a sample");

endmodule : mag_avg

`default_nettype wire

// ### hpf_comp.sv
`timescale 1ns/1ps
`default_nettype none
`include "current_defines.svh"

module hpf_comp (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  clkEn,
  // Control
  input  wire logic                  hpfEn,
  // Samples
  input  wire current_pkg::sample_s  sampleIn,
  output current_pkg::sample_s       sampleOut
);
  import current_pkg::*;

  logic signed [23:0] dcQ;
  logic signed [23:0] dcD;
  logic signed [15:0] dcEst;
  logic signed [17:0] hp;
  logic signed [17:0] lead;
  logic signed [17:0] comp;
  logic signed [15:0] hpPrevQ;
  logic signed [15:0] hpSat;
  logic signed [15:0] compSat;
  sample_s            outQ;

  function automatic logic signed [15:0] sat16(input logic signed [17:0] v);
    if (v > 18'sh07fff) begin
      sat16 = 16'sh7fff;
    end else if (v < -18'sh08000) begin
      sat16 = -16'sh8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction : sat16

  // DC tracker; its estimate is subtracted to strip offset
  // Signed operands keep the shift arithmetic for a negative estimate
  assign dcD   = dcQ + $signed({{8{sampleIn.data[15]}}, sampleIn.data})
                 - (dcQ >>> `AVG_SHIFT);
  assign dcEst = dcQ[23:8];
  assign hp    = {{2{sampleIn.data[15]}}, sampleIn.data}
                 - {{2{dcEst[15]}}, dcEst};
  assign hpSat = sat16(hp);
  // Small lead term undoes the lag the high-pass adds near line frequency
  assign lead  = $signed({{2{hpSat[15]}}, hpSat}
                         - {{2{hpPrevQ[15]}}, hpPrevQ}) >>> `COMP_SHIFT;
  assign comp  = {{2{hpSat[15]}}, hpSat} + lead;
  assign compSat = sat16(comp);
  assign sampleOut = outQ;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dcQ     <= 24'sh000000;
      hpPrevQ <= 16'sh0000;
      outQ    <= '0;
    end else if (clkEn) begin
      outQ.valid <= sampleIn.valid;
      if (sampleIn.valid) begin
        dcQ     <= dcD;
        hpPrevQ <= hpSat;
        // Filter and compensation only together, else plain bypass
        outQ.data <= hpfEn ? compSat : sampleIn.data; // R2 R3
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_hpf_bypass: assert property ( // R3
    (clkEn && !hpfEn && sampleIn.valid) |=> (outQ.data == $past(sampleIn.data)))
    else $error("bypass did not pass the sample unchanged");

endmodule : hpf_comp

`default_nettype wire

// ### current_channel_fault_select.sv
// Contract
// R1 - Whole block held in reset while the analog supply is low; pulses inhibited.
// R2 - High-pass filter on the current path when the enable pin is high.
// R3 - Phase compensation only with the filter enabled, bypassed otherwise.
// R4 - Fault flag when filtered phase and neutral magnitudes differ over 12.5%.
// R5 - Billing follows the larger current, even during a fault.
// R6 - After reset the phase input is the active input.
// R7 - Mismatch over 12.5% right after reset raises fault about one second later.
// R8 - Neutral larger than phase after reset makes neutral the active input.
// R9 - No fault detection below 0.3% of full scale.
// R10 - Inactive dropping 12.5% below active phase flags fault, keeps phase.
// R11 - Inputs filtered and averaged; fault changes about one second after event.
// R12 - Fault flag independent of billing pulse activity.
// R13 - Neutral above 114% of active phase flags fault and selects neutral.
// R14 - Each switch of active input delayed about one second.
// R15 - Return to phase only when phase exceeds 114% of neutral.
// R16 - Fault clears once inputs are within 12.5%, even before switching back.
// R17 - Exactly one input, against the common input, feeds the power path.
// R18 - Active samples routed to the multiplier; active input shown on a bit.
`timescale 1ns/1ps
`default_nettype none
`include "current_defines.svh"

module current_channel_fault_select #(
  parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
  // Clock, reset, enable
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  clkEn,
  // Supply monitor and pins
  input  wire logic                  supplyLow,
  input  wire logic                  highpassEnablePin,
  // Current samples, each against the common input
  input  wire current_pkg::sample_s  phaseCurrentInput,
  input  wire current_pkg::sample_s  neutralCurrentInput,
  // To the power multiplier
  output current_pkg::sample_s       selCurrent,
  // Status
  output logic                       activeNeutral,
  output logic                       faultFlag,
  output logic                       pulseInhibit
);
  import current_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam logic [`SETTLE_CNT_W-1:0] SETTLE_LAST =
    `SETTLE_CNT_W'(SETTLE_CYCLES - 1);

  logic                      logicRst_n;
  sample_s                   chanIn [2];
  logic [`MAG_W-1:0]         chanMag [2];
  logic [`MAG_W-1:0]         magPhase;
  logic [`MAG_W-1:0]         magNeutral;
  logic [`MAG_W-1:0]         magActive;
  logic [`MAG_W-1:0]         magOther;
  logic [`MAG_W-1:0]         magBig;
  logic [`MAG_W-1:0]         magSmall;
  logic [`MAG_W-1:0]         magDiff;
  logic [`MAG_W+2:0]         diffScaled;
  logic [29:0]               neutralScaled;
  logic [29:0]               phaseScaled;
  logic                      lightLoad;
  logic                      mismatch;
  logic                      mismatchQual;
  logic                      toNeutral;
  logic                      toPhase;
  logic                      swapCond;
  logic                      neutralBigger;
  sample_s                   muxSample;

  sel_e                      selQ;
  sel_e                      selD;
  logic                      faultQ;
  logic                      faultD;
  logic [`SETTLE_CNT_W-1:0]  faultCntQ;
  logic [`SETTLE_CNT_W-1:0]  faultCntD;
  logic [`SETTLE_CNT_W-1:0]  swapCntQ;
  logic [`SETTLE_CNT_W-1:0]  swapCntD;

  // ****************************************************************
  // Reset
  // ****************************************************************
  // Supply monitor acts as a second synchronous reset for all logic
  assign logicRst_n   = rst_n & ~supplyLow; // R1
  assign pulseInhibit = ~logicRst_n; // R1

  // ****************************************************************
  // Magnitude averaging per channel
  // ****************************************************************
  assign chanIn[0] = phaseCurrentInput;
  assign chanIn[1] = neutralCurrentInput;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : gMag
      mag_avg uMag ( // R11
        .clk       (clk),
        .rst_n     (logicRst_n),
        .clkEn     (clkEn),
        .sampleIn  (chanIn[ch]),
        .magnitude (chanMag[ch])
      );
    end
  endgenerate

  assign magPhase   = chanMag[0];
  assign magNeutral = chanMag[1];

  // ****************************************************************
  // Comparisons
  // ****************************************************************
  assign magActive = (selQ == SEL_NEUTRAL) ? magNeutral : magPhase;
  assign magOther  = (selQ == SEL_NEUTRAL) ? magPhase : magNeutral;
  assign magBig    = (magPhase > magNeutral) ? magPhase : magNeutral;
  assign magSmall  = (magPhase > magNeutral) ? magNeutral : magPhase;
  assign magDiff   = magBig - magSmall;

  // Difference measured against the active input
  assign diffScaled = {magDiff, 3'b000};
  assign mismatch   = diffScaled > {3'b000, magActive}; // R4 R10
  // Noise at light load must not raise the flag
  assign lightLoad    = magBig < `LIGHT_LEVEL; // R9
  assign mismatchQual = mismatch && !lightLoad; // R9

  // Swap thresholds both at 114 %, giving hysteresis against chatter
  assign neutralScaled = {6'h00, magNeutral} * `SWAP_DEN;
  assign phaseScaled   = {6'h00, magPhase} * `SWAP_NUM;
  assign toNeutral = neutralScaled > phaseScaled; // R13 R8
  assign toPhase   = ({6'h00, magPhase} * `SWAP_DEN) >
                     ({6'h00, magNeutral} * `SWAP_NUM); // R15
  assign swapCond  = !lightLoad &&
                     ((selQ == SEL_PHASE) ? toNeutral : toPhase);
  // Billing may only move towards the larger current
  assign neutralBigger = magNeutral > magPhase; // R5

  // ****************************************************************
  // Fault flag
  // ****************************************************************
  // Set after a full settle time, cleared at once when back in band.
  // Driven only from the magnitudes, never from pulse logic.
  always_comb begin
    faultD    = faultQ;
    faultCntD = faultCntQ;
    if (!mismatchQual) begin
      faultD    = 1'b0; // R16
      faultCntD = '0;
    end else if (faultCntQ == SETTLE_LAST) begin
      faultD    = 1'b1; // R4 R7 R11 R12
    end else begin
      faultCntD = faultCntQ + `SETTLE_CNT_W'(1);
    end
  end

  // ****************************************************************
  // Active input selection
  // ****************************************************************
  always_comb begin
    selD     = selQ;
    swapCntD = swapCntQ;
    case (selQ)
      SEL_PHASE: begin
        // Smaller neutral only flags a fault, phase stays active
        if (!swapCond) begin
          swapCntD = '0; // R10
        end else if (swapCntQ == SETTLE_LAST) begin
          selD     = SEL_NEUTRAL; // R13 R14 R8 R5
          swapCntD = '0;
        end else begin
          swapCntD = swapCntQ + `SETTLE_CNT_W'(1);
        end
      end
      SEL_NEUTRAL: begin
        if (!swapCond) begin
          swapCntD = '0;
        end else if (swapCntQ == SETTLE_LAST) begin
          selD     = SEL_PHASE; // R15 R14
          swapCntD = '0;
        end else begin
          swapCntD = swapCntQ + `SETTLE_CNT_W'(1);
        end
      end
      default: begin
        selD     = SEL_PHASE;
        swapCntD = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!logicRst_n) begin
      selQ      <= SEL_PHASE; // R6 R1
      faultQ    <= 1'b0;
      faultCntQ <= '0;
      swapCntQ  <= '0;
    end else if (clkEn) begin
      selQ      <= selD;
      faultQ    <= faultD;
      faultCntQ <= faultCntD;
      swapCntQ  <= swapCntD;
    end
  end

  assign faultFlag     = faultQ;
  assign activeNeutral = (selQ == SEL_NEUTRAL); // R18

  // ****************************************************************
  // Current path to the multiplier
  // ****************************************************************
  // One input at a time; the other is simply not routed
  assign muxSample = (selQ == SEL_NEUTRAL) ? neutralCurrentInput
                                           : phaseCurrentInput; // R17 R18

  hpf_comp uHpf ( // R2 R3
    .clk       (clk),
    .rst_n     (logicRst_n),
    .clkEn     (clkEn),
    .hpfEn     (highpassEnablePin),
    .sampleIn  (muxSample),
    .sampleOut (selCurrent)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!logicRst_n);

  a_reset_state: assert property ( // R6
    $past(!logicRst_n) |-> (!faultFlag && !activeNeutral && !selCurrent.valid))
    else $error("state not cleared after reset");

  a_fault_rise: assert property ( // R7
    $rose(faultFlag) |-> ($past(faultCntQ) == SETTLE_LAST && $past(mismatch)))
    else $error("fault rose before settle time");

  a_fault_drop: assert property ( // R16
    (clkEn && !mismatch) |=> !faultFlag)
    else $error("fault held with inputs in band");

  a_light_quiet: assert property ( // R9
    (clkEn && lightLoad) |=> !faultFlag)
    else $error("fault raised at light load");

  a_swap_delay: assert property ( // R14
    $rose(activeNeutral) |->
      ($past(swapCntQ) == SETTLE_LAST && $past(toNeutral)))
    else $error("swap to neutral without settle time");

  a_swap_back: assert property ( // R15
    $fell(activeNeutral) |->
      ($past(swapCntQ) == SETTLE_LAST && $past(toPhase)))
    else $error("return to phase without 114 percent");

  a_phase_kept: assert property ( // R10
    (clkEn && !activeNeutral && !toNeutral) |=> !activeNeutral)
    else $error("phase dropped without neutral exceeding it");

  a_route_active: assert property ( // R17
    (clkEn && !highpassEnablePin && muxSample.valid) |=>
      (selCurrent.data == (($past(activeNeutral)) ?
        $past(neutralCurrentInput.data) : $past(phaseCurrentInput.data))))
    else $error("routed sample is not the active input");

  a_frozen: assert property ( // R11
    !clkEn |=> ($stable(faultCntQ) && $stable(swapCntQ) && $stable(selQ)))
    else $error("state moved with clock enable low");

  // Reset wins over a low clock enable, so no disable here
  a_reset_clears: assert property ( // R1
    @(posedge clk) disable iff (1'b0)
    !logicRst_n |=> (!faultFlag && !activeNeutral && !selCurrent.valid))
    else $error("reset did not clear state");

  // Full settle count with a live mismatch must set the flag
  a_fault_set: assert property ( // R4
    (clkEn && mismatchQual && faultCntQ == SETTLE_LAST) |=> faultFlag)
    else $error("fault not set after settle time");

  // Light load may not move the selection either
  a_swap_load: assert property ( // R9
    ($changed(activeNeutral) && $past(logicRst_n)) |-> !$past(lightLoad))
    else $error("active input moved at light load");

  // Swap to neutral only when neutral carries the larger current
  a_swap_larger: assert property ( // R5
    $rose(activeNeutral) |-> $past(neutralBigger))
    else $error("swapped to the smaller current");

endmodule : current_channel_fault_select

`default_nettype wire

// ### current_transducer_model.sv
`timescale 1ns/1ps
`default_nettype none

module current_transducer_model (
  // Clock
  input  wire logic                  clk,
  // Amplitudes and waveform
  input  wire logic [15:0]           phaseAmp,
  input  wire logic [15:0]           neutralAmp,
  input  wire logic                  dcOnly,
  // Sample streams
  output var current_pkg::sample_s   phaseCurrentInput,
  output var current_pkg::sample_s   neutralCurrentInput
);
  import current_pkg::*;

  logic signQ;

  // ****************************************************************
  // Square wave of the set amplitude, steady level with dcOnly, one sample per cycle
  // ****************************************************************
  initial begin
    signQ               = 1'b0;
    phaseCurrentInput   = '0;
    neutralCurrentInput = '0;
  end

  // Change off the sampling edge so the design never sees a race
  always @(negedge clk) begin
    signQ                     <= ~signQ;
    phaseCurrentInput.valid   <= 1'b1;
    neutralCurrentInput.valid <= 1'b1;
    phaseCurrentInput.data    <= (signQ && !dcOnly) ?
                                 -$signed(phaseAmp) : $signed(phaseAmp);
    neutralCurrentInput.data  <= (signQ && !dcOnly) ?
                                 -$signed(neutralAmp) : $signed(neutralAmp);
  end

endmodule : current_transducer_model

`default_nettype wire

// ### tb_current_channel_fault_select.sv
`timescale 1ns/1ps
`default_nettype none

module tb_current_channel_fault_select;
  import current_pkg::*;

  // Short settle time keeps the run small
  localparam int SETTLE = 16;

  logic               clk;
  logic               rstN;
  logic               clkEn;
  logic               supplyLow;
  logic               hpfPin;
  logic               dcOnly;
  logic [15:0]        phaseAmp;
  logic [15:0]        neutralAmp;
  sample_s            phaseIn;
  sample_s            neutralIn;
  sample_s            selCurrent;
  logic               activeNeutral;
  logic               faultFlag;
  logic               pulseInhibit;
  int                 badCount;
  int                 totalChecks;
  int                 hits;
  logic               pathOn;
  logic               pathSeen;
  logic               enPrev;
  logic               expNeutral;
  logic signed [15:0] expQ[$];

  // ****************************************************************
  // Design, far side and clock
  // ****************************************************************
  current_channel_fault_select #(.SETTLE_CYCLES(SETTLE)) dut (
    .clk                 (clk),
    .rst_n               (rstN),
    .clkEn               (clkEn),
    .supplyLow           (supplyLow),
    .highpassEnablePin   (hpfPin),
    .phaseCurrentInput   (phaseIn),
    .neutralCurrentInput (neutralIn),
    .selCurrent          (selCurrent),
    .activeNeutral       (activeNeutral),
    .faultFlag           (faultFlag),
    .pulseInhibit        (pulseInhibit)
  );

  current_transducer_model xdcr (
    .clk                 (clk),
    .phaseAmp            (phaseAmp),
    .neutralAmp          (neutralAmp),
    .dcOnly              (dcOnly),
    .phaseCurrentInput   (phaseIn),
    .neutralCurrentInput (neutralIn)
  );

  initial clk = 1'b0;
  always #10 clk = ~clk;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic endSim();
    $display("Checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : endSim

  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check

  // Bounded wait on the fault flag or on the selection bit
  task automatic waitFor(input bit onSel, input logic want, input int bound);
    int n;
    n = 0;
    while (((onSel ? activeNeutral : faultFlag) !== want) && n < bound) begin
      @(negedge clk);
      n++;
    end
    if ((onSel ? activeNeutral : faultFlag) !== want) begin
      badCount++;
      $display("[FAIL] wait sel=%0b expected %0b timed out", onSel, want);
      endSim();
    end
  endtask : waitFor

  // ****************************************************************
  // Sample path: note what is taken, compare what comes out
  // ****************************************************************
  always @(posedge clk) begin
    pathSeen <= pathOn;
    enPrev   <= clkEn;
    if (pathOn && clkEn && rstN && !supplyLow) begin
      if (expNeutral ? neutralIn.valid : phaseIn.valid) begin
        expQ.push_back(expNeutral ? neutralIn.data : phaseIn.data);
      end
    end
  end

  // Valid stands while the clock enable is low, so count it only once
  always @(posedge clk) begin
    if (pathSeen && enPrev && selCurrent.valid === 1'b1) begin
      if (expQ.size() == 0) begin
        totalChecks++;
        badCount++;
        $display("[FAIL] selCurrent.valid expected 0 seen 1");
      end else begin
        check("selCurrent.data", expQ.pop_front(), selCurrent.data);
      end
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rstN        = 1'b0;
    clkEn       = 1'b1;
    supplyLow   = 1'b0;
    hpfPin      = 1'b0;
    dcOnly      = 1'b0;
    phaseAmp    = 16'h0fa0;
    neutralAmp  = 16'h0fa0;
    pathOn      = 1'b0;
    pathSeen    = 1'b0;
    enPrev      = 1'b0;
    expNeutral  = 1'b0;
    badCount    = 0;
    totalChecks = 0;
    void'($urandom(63167));
    repeat (8) @(negedge clk);
    check("pulseInhibit", 1, pulseInhibit);
    check("faultFlag", 0, faultFlag);
    check("activeNeutral", 0, activeNeutral);
    rstN = 1'b1;
    @(negedge clk);
    check("pulseInhibit", 0, pulseInhibit);
    // Matched random load, stuttering clock enable, bypass path
    phaseAmp   = 16'(1000 + $urandom % 20000);
    neutralAmp = phaseAmp;
    pathOn     = 1'b1;
    repeat (3000) begin
      @(negedge clk);
      clkEn = (($urandom % 4) != 0);
    end
    clkEn  = 1'b1;
    pathOn = 1'b0;
    @(negedge clk);
    check("faultFlag", 0, faultFlag);
    check("pendingSamples", 0, expQ.size());
    check("activeNeutral", 0, activeNeutral);
    // Pure offset is removed with the filter enabled
    hpfPin = 1'b1;
    dcOnly = 1'b1;
    phaseAmp = 16'h0bb8;
    neutralAmp = 16'h0bb8;
    repeat (4000) @(negedge clk);
    check("hpfResidue", 1, selCurrent.data < 16'sh0040 &&
          selCurrent.data > -16'sh0040);
    hpfPin = 1'b0;
    dcOnly = 1'b0;
    // Inactive neutral drops 25 % below phase
    phaseAmp   = 16'h0fa0;
    neutralAmp = 16'h0bb8;
    waitFor(1'b0, 1'b1, 5000);
    check("activeNeutral", 0, activeNeutral);
    neutralAmp = 16'h0fa0;
    waitFor(1'b0, 1'b0, 5000);
    // Neutral 125 % of phase: fault and swap
    neutralAmp = 16'h1388;
    waitFor(1'b1, 1'b1, 5000);
    check("faultFlag", 1, faultFlag);
    expNeutral = 1'b1;
    pathOn     = 1'b1;
    repeat (200) @(negedge clk);
    pathOn = 1'b0;
    // Supply drop in mid-run acts as reset
    supplyLow = 1'b1;
    repeat (2) @(negedge clk);
    check("pendingSamples", 0, expQ.size());
    check("pulseInhibit", 1, pulseInhibit);
    check("faultFlag", 0, faultFlag);
    check("activeNeutral", 0, activeNeutral);
    supplyLow = 1'b0;
    @(negedge clk);
    check("pulseInhibit", 0, pulseInhibit);
    waitFor(1'b0, 1'b1, 5000);
    waitFor(1'b1, 1'b1, 5000);
    // Phase back within band: fault clears, neutral stays active
    phaseAmp = 16'h12c0;
    waitFor(1'b0, 1'b0, 5000);
    check("activeNeutral", 1, activeNeutral);
    phaseAmp = 16'h1770;
    waitFor(1'b1, 1'b0, 5000);
    // Light load mismatch never flags
    rstN = 1'b0;
    phaseAmp   = 16'h0050;
    neutralAmp = 16'h0014;
    repeat (2) @(negedge clk);
    rstN = 1'b1;
    hits = 0;
    repeat (3000) begin
      @(negedge clk);
      if (faultFlag !== 1'b0) hits++;
    end
    check("lightFaults", 0, hits);
    endSim();
  end

endmodule : tb_current_channel_fault_select

`default_nettype wire
